// file: pfd_device.sv
// Synthesizer digital core: serial registers, feedback and reference counters,
// monitors, reference output divider, both phase detectors and lock indicator.
// Assumes all link and loop inputs are asynchronous to CLK and far slower.
//
// Functional notes
// (R1) Feedback monitor static low when disabled, disabled at reset
// (R2) 16-bit down counter divides VCO by ratio
// (R3) Enabled feedback monitor rests low, pulses high
// (R4) Each VCO rising edge decrements feedback counter
// (R5) Single-ended: low leading, high lagging, else float
// (R6) Bit 7 inverts single, swaps double outputs
// (R7) Double-ended: VCO side low leading, reference lagging
// (R8) Matched: both outputs pulse low together briefly
// (R9) Bit 6 picks single or double detector
// (R10) Bit 5 enables lock indicator, else low
// (R11) Lock indicator high, low pulses on mismatch
// (R12) Lock indicator held low after reset
// (R13) Bits 4..2 select reference output division
// (R14) Bit 1 enables feedback monitor, else low
// (R15) Bit 0 enables reference monitor, else low
// (R16) Eight clocks store configuration byte only
// (R17) Sixteen clocks store ratio, jam-load counters
// (R18) Controller keeps divided VCO at most 2 MHz
// (R19) Controller issues serial reset after bad power-up
// (R20) Select low, MSB first, length picks register
// (R21) Nine to thirteen clocks reset the core
// (R22) Each reference rising edge decrements reference counter
// (R23) Detectors compare rising edges, width tracks offset
`timescale 1ns/1ps
`include "pfd_params.svh"

module pfd_device
   import pfd_pkg::*;
(
   input  wire logic CLK,
   input  wire logic RST,
   pfd_if.device     LINK,
   input  wire logic REFERENCE_OSCILLATOR_INPUT,
   input  wire logic VCO_INPUT,
   output logic      FEEDBACK_MONITOR,
   output logic      REFERENCE_MONITOR,
   output logic      REFERENCE_OUTPUT,
   output logic      LOCK_INDICATOR,
   output logic      SINGLE_ENDED_DETECTOR_OUT,
   output logic      SINGLE_ENDED_DETECTOR_OE,
   output logic      VCO_SIDE_DETECTOR_N,
   output logic      REFERENCE_SIDE_DETECTOR_N
);

   localparam int NSYNC = 5;
   localparam int IDX_SEL = 0;
   localparam int IDX_SCLK = 1;
   localparam int IDX_DATA = 2;
   localparam int IDX_OSC = 3;
   localparam int IDX_VCO = 4;

   logic [NSYNC-1:0]          raw_in;
   logic [NSYNC-1:0]          meta_q;
   logic [NSYNC-1:0]          sync_q;
   logic [NSYNC-1:0]          prev_q;
   logic [NSYNC-1:0]          rise;
   logic [`PFD_SHIFT_W-1:0]   shift_q;
   logic [5:0]                len_q;
   pfd_cfg_t                  cfg_q;
   logic [15:0]               n_q;
   logic [14:0]               r_q;
   logic [15:0]               fb_cnt_q;
   logic [14:0]               ref_cnt_q;
   logic [3:0]                pre_q;
   logic                      jam_q;
   logic                      soft_q;
   logic                      sel_rise;
   logic                      fb_evt;
   logic                      ref_evt;
   logic                      lead_q;
   logic                      lag_q;
   logic                      coin_q;
   logic                      fb_mon_q;
   logic                      ref_mon_q;
   logic                      ref_level;

   // ==========================================================
   // Input synchronisers
   assign raw_in = {VCO_INPUT, REFERENCE_OSCILLATOR_INPUT, LINK.serial_data,
                    LINK.serial_clk, LINK.port_select_n};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge CLK or posedge RST) begin
            // Select idles high; resetting its chain high avoids a false rise
            if (RST) begin
               meta_q[gi] <= (gi == IDX_SEL) ? 1'b1 : 1'b0;
               sync_q[gi] <= (gi == IDX_SEL) ? 1'b1 : 1'b0;
               prev_q[gi] <= (gi == IDX_SEL) ? 1'b1 : 1'b0;
            end else begin
               meta_q[gi] <= raw_in[gi];
               sync_q[gi] <= meta_q[gi];
               prev_q[gi] <= sync_q[gi];
            end
         end
         assign rise[gi] = sync_q[gi] & ~prev_q[gi];
      end
   endgenerate

   // ==========================================================
   // Serial port
   assign sel_rise = rise[IDX_SEL];

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         shift_q <= '0;
         len_q   <= '0;
      end else if (sync_q[IDX_SEL]) begin
         len_q <= '0;
      end else if (rise[IDX_SCLK]) begin
         shift_q <= {shift_q[`PFD_SHIFT_W-2:0], sync_q[IDX_DATA]}; // [R20]
         if (len_q != `PFD_LEN_SAT) begin
            len_q <= len_q + 6'h01;
         end
      end
   end

   // Frame length alone picks the target; stray lengths are dropped
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cfg_q <= `PFD_CFG_RESET;
      end else if (soft_q) begin
         cfg_q <= `PFD_CFG_RESET; // [R21]
      end else if (sel_rise && len_q == `PFD_LEN_CFG) begin
         cfg_q <= shift_q[7:0]; // [R16]
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         n_q <= `PFD_N_RESET;
      end else if (soft_q) begin
         n_q <= `PFD_N_RESET;
      end else if (sel_rise && len_q == `PFD_LEN_N) begin
         n_q <= shift_q[15:0]; // [R17]
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         r_q <= `PFD_R_RESET;
      end else if (soft_q) begin
         r_q <= `PFD_R_RESET;
      end else if (sel_rise && (len_q == `PFD_LEN_R_SHORT || len_q == `PFD_LEN_R_LONG)) begin
         r_q <= shift_q[14:0]; // [R20]
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         jam_q  <= 1'b0;
         soft_q <= 1'b0;
      end else begin
         jam_q  <= sel_rise && len_q == `PFD_LEN_N; // [R17]
         soft_q <= sel_rise && len_q >= `PFD_LEN_RST_MIN
                            && len_q <= `PFD_LEN_RST_MAX; // [R21]
      end
   end

   // ==========================================================
   // Counters; jam happens one cycle after the ratio lands in n_q
   assign fb_evt  = rise[IDX_VCO] && fb_cnt_q <= `PFD_FB_TERM;
   assign ref_evt = rise[IDX_OSC] && ref_cnt_q <= `PFD_REF_TERM;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         fb_cnt_q <= `PFD_N_RESET;
      end else if (jam_q || soft_q) begin
         fb_cnt_q <= n_q; // [R17]
      end else if (fb_evt) begin
         fb_cnt_q <= n_q; // [R2]
      end else if (rise[IDX_VCO]) begin
         fb_cnt_q <= fb_cnt_q - 16'h0001; // [R4]
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ref_cnt_q <= `PFD_R_RESET;
      end else if (jam_q || soft_q) begin
         ref_cnt_q <= r_q; // [R17]
      end else if (ref_evt) begin
         ref_cnt_q <= r_q;
      end else if (rise[IDX_OSC]) begin
         ref_cnt_q <= ref_cnt_q - 15'h0001; // [R22]
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pre_q <= '0;
      end else if (rise[IDX_OSC]) begin
         pre_q <= pre_q + 4'h1;
      end
   end

   // ==========================================================
   // Monitors: high for one input period after each terminal count
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         fb_mon_q <= 1'b0; // [R1]
      end else if (!cfg_q.fb_mon_en) begin
         fb_mon_q <= 1'b0; // [R14]
      end else if (fb_evt) begin
         fb_mon_q <= 1'b1; // [R3]
      end else if (rise[IDX_VCO]) begin
         fb_mon_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ref_mon_q <= 1'b0;
      end else if (!cfg_q.ref_mon_en) begin
         ref_mon_q <= 1'b0; // [R15]
      end else if (ref_evt) begin
         ref_mon_q <= 1'b1;
      end else if (rise[IDX_OSC]) begin
         ref_mon_q <= 1'b0;
      end
   end

   // ==========================================================
   // Phase/frequency detector core
   // Coincident edges clear both sides and leave one-cycle overlap, so there is no dead zone
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         lead_q <= 1'b0;
         lag_q  <= 1'b0;
         coin_q <= 1'b0;
      end else if (jam_q || soft_q) begin
         lead_q <= 1'b0;
         lag_q  <= 1'b0;
         coin_q <= 1'b0;
      end else if ((lead_q || fb_evt) && (lag_q || ref_evt)) begin
         lead_q <= 1'b0; // [R23]
         lag_q  <= 1'b0;
         coin_q <= 1'b1; // [R8]
      end else begin
         lead_q <= lead_q || fb_evt; // [R23]
         lag_q  <= lag_q || ref_evt;
         coin_q <= 1'b0;
      end
   end

   // ==========================================================
   // Registered outputs
   always_comb begin
      if (cfg_q.ref_div == `PFD_REF_OFF) begin
         ref_level = 1'b0; // [R13]
      end else if (cfg_q.ref_div == `PFD_REF_DIRECT) begin
         ref_level = sync_q[IDX_OSC];
      end else if (cfg_q.ref_div == `PFD_REF_DIV2) begin
         ref_level = pre_q[0];
      end else if (cfg_q.ref_div == `PFD_REF_DIV4) begin
         ref_level = pre_q[1];
      end else begin
         ref_level = cfg_q.ref_div[0] ? pre_q[3] : pre_q[2]; // [R13]
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         FEEDBACK_MONITOR  <= 1'b0;
         REFERENCE_MONITOR <= 1'b0;
         REFERENCE_OUTPUT  <= 1'b0;
         LOCK_INDICATOR    <= 1'b0; // [R12]
      end else begin
         FEEDBACK_MONITOR  <= fb_mon_q;
         REFERENCE_MONITOR <= ref_mon_q;
         REFERENCE_OUTPUT  <= ref_level;
         LOCK_INDICATOR    <= cfg_q.lock_en && !(lead_q || lag_q || coin_q); // [R10] [R11]
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         SINGLE_ENDED_DETECTOR_OUT <= 1'b0;
         SINGLE_ENDED_DETECTOR_OE  <= 1'b0;
         VCO_SIDE_DETECTOR_N       <= 1'b1;
         REFERENCE_SIDE_DETECTOR_N <= 1'b1;
      end else if (cfg_q.single_sel) begin
         SINGLE_ENDED_DETECTOR_OE  <= lead_q || lag_q; // [R5] [R9]
         SINGLE_ENDED_DETECTOR_OUT <= lag_q ^ cfg_q.invert; // [R6]
         VCO_SIDE_DETECTOR_N       <= 1'b1; // [R9]
         REFERENCE_SIDE_DETECTOR_N <= 1'b1;
      end else begin
         SINGLE_ENDED_DETECTOR_OE  <= 1'b0; // [R9]
         SINGLE_ENDED_DETECTOR_OUT <= 1'b0;
         VCO_SIDE_DETECTOR_N       <= !((cfg_q.invert ? lag_q : lead_q) || coin_q); // [R7] [R6]
         REFERENCE_SIDE_DETECTOR_N <= !((cfg_q.invert ? lead_q : lag_q) || coin_q); // [R7] [R8]
      end
   end

endmodule : pfd_device

// file: pfd_params.svh
// Constants shared by the synthesizer core and its serial controller.
// Assumes inclusion by bare name from any file that needs them.
`ifndef PFD_PARAMS_SVH
`define PFD_PARAMS_SVH

// ==========================================================
// Register reset values and counter terminal counts
`define PFD_CFG_RESET     8'h10
`define PFD_N_RESET       16'h0028
`define PFD_R_RESET       15'h0005
`define PFD_FB_TERM       16'h0001
`define PFD_REF_TERM      15'h0001

// ==========================================================
// Serial frame lengths in clocks
`define PFD_LEN_CFG       6'h08
`define PFD_LEN_N         6'h10
`define PFD_LEN_R_SHORT   6'h0F
`define PFD_LEN_R_LONG    6'h18
`define PFD_LEN_RST_MIN   6'h09
`define PFD_LEN_RST_MAX   6'h0D
`define PFD_LEN_SAT       6'h21
`define PFD_SHIFT_W       24

// ==========================================================
// Reference output divider codes
`define PFD_REF_OFF       3'h0
`define PFD_REF_DIRECT    3'h1
`define PFD_REF_DIV2      3'h2
`define PFD_REF_DIV4      3'h3

// ==========================================================
// Controller register map and link timing
`define PFD_REG_DATA      8'h00
`define PFD_REG_CTRL      8'h04
`define PFD_REG_STATUS    8'h08
`define PFD_CLK_NS        5
`define PFD_SCLK_HALF_NS  40
`define PFD_SCLK_HALF_CYC ((`PFD_SCLK_HALF_NS + `PFD_CLK_NS - 1) / `PFD_CLK_NS)

`endif

// file: pfd_pkg.sv
// Types shared by the synthesizer core and its serial controller.
// Assumes nothing beyond a SystemVerilog compiler.
package pfd_pkg;

   // Configuration byte, bit 7 first
   typedef struct packed {
      logic       invert;
      logic       single_sel;
      logic       lock_en;
      logic [2:0] ref_div;
      logic       fb_mon_en;
      logic       ref_mon_en;
   } pfd_cfg_t;

   typedef enum logic [2:0] {
      PFD_IDLE = 3'h0,
      PFD_SEL  = 3'h1,
      PFD_LOW  = 3'h3,
      PFD_HIGH = 3'h2,
      PFD_DONE = 3'h6,
      PFD_GAP  = 3'h4
   } pfd_host_state_t;

endpackage : pfd_pkg

// file: pfd_if.sv
// Three-wire serial link between the controller and the synthesizer core.
// Assumes both ends are clocked by their own CLK; the link clock is a plain signal.
`timescale 1ns/1ps
interface pfd_if;
   logic port_select_n;
   logic serial_clk;
   logic serial_data;

   modport host   (output port_select_n, output serial_clk, output serial_data);
   modport device (input port_select_n, input serial_clk, input serial_data);
endinterface : pfd_if

// file: pfd_host.sv
// Serial controller: APB registers take a frame (data and clock count) and
// shift it out on the three-wire link, MSB first, with a divided link clock.
// Assumes an APB master on CLK and a core on the far end of pfd_if.
`timescale 1ns/1ps
`include "pfd_params.svh"

module pfd_host
   import pfd_pkg::*;
#(
   parameter int HALF_CYC = `PFD_SCLK_HALF_CYC
)(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   pfd_if.host              LINK
);

   logic [31:0]      data_q;
   logic [31:0]      sh_q;
   logic [5:0]       left_q;
   logic [15:0]      div_q;
   logic             sclk_q;
   logic             sel_n_q;
   logic             sdata_q;
   logic             go;
   logic             wr_ok;
   logic             tick;
   pfd_host_state_t  state_q;

   assign LINK.port_select_n = sel_n_q;
   assign LINK.serial_clk    = sclk_q;
   assign LINK.serial_data   = sdata_q;

   // ==========================================================
   // APB slave, no wait states; answer is latched in the setup cycle
   assign wr_ok = PSEL && PENABLE && PREADY && PWRITE;
   assign go    = wr_ok && PADDR == `PFD_REG_CTRL && state_q == PFD_IDLE
                  && PWDATA[5:0] != 6'h00;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= '0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= 1'b0;
         PRDATA  <= '0;
         if (PSEL && !PENABLE) begin
            if (PADDR == `PFD_REG_DATA) begin
               PRDATA <= data_q;
            end else if (PADDR == `PFD_REG_STATUS) begin
               PRDATA <= {31'h00000000, state_q != PFD_IDLE};
            end else if (PADDR != `PFD_REG_CTRL) begin
               PSLVERR <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         data_q <= '0;
      end else if (wr_ok && PADDR == `PFD_REG_DATA) begin
         data_q <= PWDATA;
      end
   end

   // ==========================================================
   // Link clock divider and frame sequencer
   // Select changes only while the link clock is low, keeping the core in step
   assign tick = div_q == 16'h0000;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         div_q <= '0;
      end else if (go || tick) begin
         div_q <= 16'(HALF_CYC - 1);
      end else begin
         div_q <= div_q - 16'h0001;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_q <= PFD_IDLE;
         sel_n_q <= 1'b1;
         sclk_q  <= 1'b0;
         sdata_q <= 1'b0;
         sh_q    <= '0;
         left_q  <= '0;
      end else begin
         case (state_q)
            PFD_IDLE: begin
               if (go) begin
                  sh_q    <= data_q << (7'h20 - {1'b0, PWDATA[5:0]}); // [R20]
                  left_q  <= PWDATA[5:0];
                  sel_n_q <= 1'b0; // [R20]
                  state_q <= PFD_SEL;
               end
            end
            PFD_SEL: begin
               if (tick) begin
                  sdata_q <= sh_q[31];
                  sh_q    <= {sh_q[30:0], 1'b0};
                  state_q <= PFD_LOW;
               end
            end
            PFD_LOW: begin
               if (tick) begin
                  sclk_q  <= 1'b1;
                  left_q  <= left_q - 6'h01;
                  state_q <= PFD_HIGH;
               end
            end
            PFD_HIGH: begin
               if (tick) begin
                  sclk_q <= 1'b0;
                  if (left_q == 6'h00) begin
                     state_q <= PFD_DONE;
                  end else begin
                     sdata_q <= sh_q[31];
                     sh_q    <= {sh_q[30:0], 1'b0};
                     state_q <= PFD_LOW;
                  end
               end
            end
            PFD_DONE: begin
               if (tick) begin
                  sel_n_q <= 1'b1; // [R16] [R17] [R21]
                  state_q <= PFD_GAP;
               end
            end
            PFD_GAP: begin
               if (tick) begin
                  state_q <= PFD_IDLE;
               end
            end
            default: begin
               state_q <= PFD_IDLE;
            end
         endcase
      end
   end

endmodule : pfd_host

// file: pfd_monitor.sv
// Concurrent checks on the serial link and on the detector outputs of the core.
// Assumes one CLK domain, instantiation beside pfd_if in the bench, no bind.
`timescale 1ns/1ps

module pfd_monitor (
   input wire logic CLK,
   input wire logic RST,
   input wire logic port_select_n,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic FEEDBACK_MONITOR,
   input wire logic REFERENCE_MONITOR,
   input wire logic LOCK_INDICATOR,
   input wire logic SINGLE_ENDED_DETECTOR_OE,
   input wire logic VCO_SIDE_DETECTOR_N,
   input wire logic REFERENCE_SIDE_DETECTOR_N
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // ==========================================================
   // Link framing
   property p_sclk_idle;
      port_select_n |-> !serial_clk;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("link clock high while select inactive");

   // Select may only move while the link clock rests low
   property p_sel_edge;
      $changed(port_select_n) |-> !serial_clk && !$past(serial_clk);
   endproperty
   a_sel_edge: assert property (p_sel_edge)
      else $error("select moved while link clock high");

   property p_data_hold;
      serial_clk && $past(serial_clk) |-> $stable(serial_data);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("data changed while link clock high");

   property p_frame_end;
      $fell(port_select_n) |-> ##[1:400] $rose(port_select_n);
   endproperty
   a_frame_end: assert property (p_frame_end)
      else $error("frame never closed");

   property p_sel_gap;
      $rose(port_select_n) |-> port_select_n[*2];
   endproperty
   a_sel_gap: assert property (p_sel_gap)
      else $error("select high too briefly between frames");

   // ==========================================================
   // Core outputs
   property p_rst_quiet;
      $past(RST) |-> !LOCK_INDICATOR && !FEEDBACK_MONITOR && !REFERENCE_MONITOR;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("indicator or monitor active after reset");

   property p_single_excl;
      SINGLE_ENDED_DETECTOR_OE |-> VCO_SIDE_DETECTOR_N && REFERENCE_SIDE_DETECTOR_N;
   endproperty
   a_single_excl: assert property (p_single_excl)
      else $error("double outputs active while single detector drives");

   property p_coin_short;
      !VCO_SIDE_DETECTOR_N && !REFERENCE_SIDE_DETECTOR_N
         |=> VCO_SIDE_DETECTOR_N && REFERENCE_SIDE_DETECTOR_N;
   endproperty
   a_coin_short: assert property (p_coin_short)
      else $error("coincidence pulse longer than one cycle");

   c_coin: cover property (!VCO_SIDE_DETECTOR_N && !REFERENCE_SIDE_DETECTOR_N);
endmodule : pfd_monitor

// file: tb.sv
// Self-checking bench: APB drives the controller, which frames the core over pfd_if.
// Assumes the design files and pfd_params.svh are compiled first.
`timescale 1ns/1ps
`include "pfd_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb;
   import pfd_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        ref_in = 1'b0;
   logic        vco_in = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, fb_mon, ref_mon, ref_out, lock, se_out, se_oe;
   logic        vco_n, ref_n;
   int          n_fail = 0;
   int          n_checks = 0;
   int          cnt[10];
   int          divs[8] = '{0, 1, 2, 4, 8, 16, 8, 16};

   pfd_if lnk();

   // ==========================================================
   // Clock and design
   always #2.5 clk = ~clk;

   pfd_host #(.HALF_CYC(2)) i_pfd_host (.CLK(clk), .RST(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(lnk.host));

   pfd_device i_pfd_device (.CLK(clk), .RST(rst), .LINK(lnk.device),
      .REFERENCE_OSCILLATOR_INPUT(ref_in), .VCO_INPUT(vco_in),
      .FEEDBACK_MONITOR(fb_mon), .REFERENCE_MONITOR(ref_mon), .REFERENCE_OUTPUT(ref_out),
      .LOCK_INDICATOR(lock), .SINGLE_ENDED_DETECTOR_OUT(se_out),
      .SINGLE_ENDED_DETECTOR_OE(se_oe), .VCO_SIDE_DETECTOR_N(vco_n),
      .REFERENCE_SIDE_DETECTOR_N(ref_n));

   pfd_monitor u_mon (.CLK(clk), .RST(rst), .port_select_n(lnk.port_select_n),
      .serial_clk(lnk.serial_clk), .serial_data(lnk.serial_data),
      .FEEDBACK_MONITOR(fb_mon), .REFERENCE_MONITOR(ref_mon), .LOCK_INDICATOR(lock),
      .SINGLE_ENDED_DETECTOR_OE(se_oe), .VCO_SIDE_DETECTOR_N(vco_n),
      .REFERENCE_SIDE_DETECTOR_N(ref_n));

   // ==========================================================
   // Tasks
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Look at the settled answer mid-cycle; it is taken at the next rising edge
      do begin
         @(negedge clk);
         k++;
      end while (pready !== 1'b1 && k < 64);
      rd = prdata;
      err = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 64) begin
         n_fail++;
         print_verdict();
      end
   endtask : apb

   // Sends the low len bits of d, then lets the core commit and jam-load
   task automatic frame(input logic [31:0] d, input logic [5:0] len);
      int k;
      k = 0;
      apb(1'b1, `PFD_REG_DATA, d);
      apb(1'b1, `PFD_REG_CTRL, {26'h0, len});
      do begin
         apb(1'b0, `PFD_REG_STATUS, 32'h0);
         k++;
      end while (rd[0] !== 1'b0 && k < 200);
      if (k >= 200) begin
         n_fail++;
         print_verdict();
      end
      repeat (8) @(posedge clk);
   endtask : frame

   // Both inputs start low and rise together, so equal ratios stay in phase
   task automatic run(input int n, input int rh);
      logic [2:0] p;
      p = 3'h0;
      for (int j = 0; j < 10; j++) cnt[j] = 0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         ref_in <= ((i / rh) % 2) == 0;
         vco_in <= ((i / 2) % 2) == 0;
         if (ref_out && !p[0]) cnt[0]++;
         if (fb_mon && !p[1]) cnt[1]++;
         if (ref_mon && !p[2]) cnt[2]++;
         if (!vco_n && ref_n) cnt[3]++;
         if (vco_n && !ref_n) cnt[4]++;
         if (!vco_n && !ref_n) cnt[5]++;
         if (se_oe && se_out) cnt[6]++;
         if (se_oe && !se_out) cnt[7]++;
         if (lock) cnt[8]++;
         if (!lock) cnt[9]++;
         p = {ref_mon, fb_mon, ref_out};
      end
      @(posedge clk);
      ref_in <= 1'b0;
      vco_in <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : run

   function automatic logic near(input int g, input int e);
      return (g >= e - 1) && (g <= e + 1);
   endfunction : near

   // ==========================================================
   // Scenarios
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      `CHK({fb_mon, ref_mon, lock, se_oe, vco_n, ref_n}, 6'b000011)
      apb(1'b1, `PFD_REG_DATA, 32'h12345678);
      apb(1'b0, `PFD_REG_DATA, 32'h0);
      `CHK(rd, 32'h12345678)
      apb(1'b0, 8'h0C, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      run(256, 4);
      `CHK(near(cnt[0], 4), 1'b1)
      for (int c = 0; c < 8; c++) begin
         frame({24'h0, 3'h0, c[2:0], 2'h0}, 6'd8);
         run(256, 4);
         `CHK(near(cnt[0], (divs[c] == 0) ? 0 : 32 / divs[c]), 1'b1)
      end
      `CHK(cnt[1] + cnt[2] + cnt[8], 0)
      frame(32'h23, 6'd8);
      run(800, 4);
      `CHK(near(cnt[2], 20), 1'b1)
      `CHK(near(cnt[1], 5), 1'b1)
      `CHK({cnt[3] == 0, cnt[4] > 0, cnt[9] > 0}, 3'b111)
      `CHK(cnt[6] + cnt[7], 0)
      frame(32'hA3, 6'd8);
      run(400, 4);
      `CHK({cnt[4] == 0, cnt[3] > 0}, 2'b11)
      frame(32'h63, 6'd8);
      run(400, 4);
      `CHK(cnt[3] + cnt[4] + cnt[5], 0)
      `CHK({cnt[7] == 0, cnt[6] > 0}, 2'b11)
      frame(32'hE3, 6'd8);
      run(400, 4);
      `CHK({cnt[6] == 0, cnt[7] > 0}, 2'b11)
      frame(32'hAB0064, 6'd24);
      // Jam both counters so the lead run starts from a clean detector
      frame(32'h28, 6'd16);
      frame(32'h23, 6'd8);
      run(1600, 4);
      `CHK({cnt[4] == 0, cnt[3] > 0}, 2'b11)
      `CHK(near(cnt[2], 2), 1'b1)
      // A reset frame also clears any detector state left by the lead run
      frame(32'h0, 6'd12);
      `CHK({fb_mon, ref_mon, lock, se_oe, vco_n, ref_n}, 6'b000011)
      frame(32'h28, 6'd15);
      frame(32'h28, 6'd16);
      frame(32'h23, 6'd8);
      frame(32'h0, 6'd7);
      run(1280, 2);
      `CHK({cnt[3] + cnt[4] == 0, cnt[5] > 0}, 2'b11)
      `CHK(cnt[8] > cnt[9], 1'b1)
      `CHK({near(cnt[1], 8), near(cnt[2], 8)}, 2'b11)
      print_verdict();
   end
endmodule : tb
